// [shared/ntp_pkg.sv]
package ntp_pkg;
   localparam int BUF_DEPTH = 3000;
   localparam logic [15:0] BUF_LAST = 16'h0BB7;
   // word indices; byte address is four times the index
   localparam logic [15:0] IDX_GEN_CTRL = 16'hFFFE;
   localparam logic [15:0] IDX_STATUS = 16'hFFFC;
   localparam logic [15:0] IDX_INT_EN = 16'hFFFA;
   localparam logic [15:0] IDX_INT_FLAG = 16'hFFF8;
   localparam logic [15:0] IDX_FILE_ID = 16'hFFF6;
   localparam logic [15:0] IDX_HOST_RESP = 16'hFFF4;
   localparam logic [15:0] IDX_BLOCK_LEN = 16'hFFF2;
   localparam logic [15:0] IDX_FILE_OFS = 16'hFFF0;
   localparam logic [15:0] IDX_BUF_START = 16'hFFEE;
   localparam logic [15:0] IDX_CUSTOM_SW = 16'hFFEC;
   localparam logic [15:0] IDX_RATE_CAP = 16'hFFEA;
   localparam logic [15:0] IDX_MAP_VER = 16'hFFE8;
   localparam logic [15:0] IDX_MLE_REG = 16'hFFE6;
   localparam logic [15:0] IDX_MLC_REG = 16'hFFE4;
   localparam logic [15:0] IDX_SEQ_KEY = 16'hFFE0;
   localparam logic [15:0] IDX_SEQ_CAP = 16'h2ABA;
   localparam logic [15:0] IDX_SEQ_ARM = 16'h27B8;
   localparam logic [15:0] SEQ_KEY_OPEN = 16'h004E;
   localparam logic [15:0] SEQ_CTRL_VAL = 16'h0080;
   localparam logic [15:0] SEQ_ZERO = 16'h0000;
   // field positions and reset values
   localparam int CAP_RSVD_BIT = 3;
   localparam logic [7:0] CAP_RESET = 8'h00;
   localparam int CTRL_RF_EN = 0;
   localparam int HR_SERVICED = 0;
   localparam int HR_CUSTOM = 1;
   localparam int HR_EXISTS = 2;
   localparam int INT_GEN_T4 = 0;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] INT_EN_RESET = 16'h0001;
   localparam logic [7:0] MAP_VER_MAX = 8'h20;
   localparam logic [15:0] MLE = 16'h00F9;
   localparam logic [15:0] MLC = 16'h00F6;
   localparam logic [15:0] SW_OK = 16'h9000;
   localparam logic [15:0] SW_NOT_FOUND = 16'h6A82;
   // reader link opcodes and answer bytes
   localparam logic [7:0] OP_REQB = 8'h05;
   localparam logic [7:0] OP_WUPB = 8'h06;
   localparam logic [7:0] OP_ATTRIB = 8'h1D;
   localparam logic [7:0] OP_HLTB = 8'h50;
   localparam logic [7:0] OP_SELECT = 8'hA4;
   localparam logic [7:0] OP_READ = 8'hB0;
   localparam logic [7:0] OP_UPDATE = 8'hD6;
   localparam logic [7:0] ATQB_HDR = 8'h50;
   localparam logic [7:0] ATTRIB_ANS = 8'h00;
   typedef enum logic [1:0] {
      T4_NONE = 2'b00, T4_SELECT = 2'b01, T4_READ = 2'b10,
      T4_UPDATE = 2'b11
   } ntp_t4cmd_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_HOST = 3'b001, ST_DATA = 3'b010,
      ST_SW1 = 3'b011, ST_SW2 = 3'b100
   } ntp_state_t;
   typedef struct packed {
      logic strobe;
      logic eof;
      logic [7:0] data;
   } ntp_rx_t;
   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } ntp_tx_t;
endpackage : ntp_pkg

// [verilog/ntp_link_rx.sv]
`timescale 1ns/1ps
module ntp_link_rx
   import ntp_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic reset_n,
   // reader link pins
   input wire logic link_clk,
   input wire logic link_frame,
   input wire logic [7:0] link_data,
   // received bytes
   output ntp_rx_t rx
);
   logic [9:0] pins;
   logic [9:0] sync1;
   logic [9:0] sync2;
   logic prev_clk;
   logic prev_frame;
   assign pins = {link_frame, link_clk, link_data};
   genvar i;
   generate
      for (i = 0; i < 10; i++) begin : g_sync
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               sync1[i] <= 1'b0;
               sync2[i] <= 1'b0;
            end else begin
               sync1[i] <= pins[i];
               sync2[i] <= sync1[i];
            end
         end
      end
   endgenerate
   // edges judged on second stage only
   wire clk_rise = sync2[8] & ~prev_clk;
   wire frame_fall = ~sync2[9] & prev_frame;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_clk <= 1'b0;
         prev_frame <= 1'b0;
         rx <= '0;
      end else begin
         prev_clk <= sync2[8];
         prev_frame <= sync2[9];
         rx.strobe <= clk_rise & sync2[9];
         rx.eof <= frame_fall;
         rx.data <= sync2[7:0];
      end
   end
endmodule : ntp_link_rx

// [verilog/ntp_buffer.sv]
`timescale 1ns/1ps
module ntp_buffer
   import ntp_pkg::*;
(
   // system
   input wire logic clk,
   // write port
   input wire logic wr_en,
   input wire logic [11:0] wr_idx,
   input wire logic [7:0] wr_data,
   // read ports
   input wire logic [11:0] rda_idx,
   output logic [7:0] rda_data,
   input wire logic [11:0] rdb_idx,
   output logic [7:0] rdb_data
);
   // data store, no reset: contents only count once the host writes
   logic [7:0] mem [0:BUF_DEPTH-1];
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end
   assign rda_data = mem[rda_idx];
   assign rdb_data = mem[rdb_idx];
endmodule : ntp_buffer

// [verilog/ntp_request_proxy.sv]
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module ntp_request_proxy
   import ntp_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic reset_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // reader link in
   input wire logic link_clk,
   input wire logic link_frame,
   input wire logic [7:0] link_data,
   // reader link out
   output ntp_tx_t tx,
   // host service request
   output logic host_interrupt_pin
);
   ntp_rx_t rx;
   ntp_state_t state;
   ntp_t4cmd_t cmd_field;
   logic dp_wr;
   logic [15:0] dp_idx;
   logic [15:0] gen_ctrl;
   logic [15:0] int_en;
   logic [15:0] int_flag;
   logic [15:0] file_id;
   logic [15:0] host_resp;
   logic [15:0] block_len;
   logic [15:0] file_ofs;
   logic [15:0] buf_start;
   logic [15:0] custom_sw;
   logic [7:0] rate_cap;
   logic [7:0] cap_pend;
   logic [2:0] seq_step;
   logic [7:0] op;
   logic [7:0] arg1;
   logic [7:0] arg2;
   logic [7:0] arg3;
   logic [2:0] nbytes;
   logic halted;
   logic active;
   logic sel_ok;
   logic [15:0] sel_fid;
   logic cache_ok;
   logic [15:0] cache_ofs;
   logic [15:0] cache_len;
   logic [15:0] rd_ofs;
   logic [7:0] rd_len;
   logic [11:0] data_idx;
   logic [7:0] remain;
   logic [15:0] sw;
   logic [31:0] next_hrdata;
   logic [7:0] bus_buf_data;
   logic [7:0] tx_buf_data;

   ntp_link_rx u_rx (
      .clk(clk),
      .reset_n(reset_n),
      .link_clk(link_clk),
      .link_frame(link_frame),
      .link_data(link_data),
      .rx(rx)
   );

   // bus decode; only whole-word transfers are defined
   wire addr_ok = hsel & hready & htrans[1];
   wire [15:0] ap_idx = haddr[17:2];
   wire wr = dp_wr;
   wire [15:0] wdat = hwdata[15:0];
   wire wr_buf = wr & (dp_idx <= BUF_LAST);
   wire wr_ctrl = wr & (dp_idx == IDX_GEN_CTRL);
   wire wr_en_reg = wr & (dp_idx == IDX_INT_EN);
   wire wr_flag = wr & (dp_idx == IDX_INT_FLAG);
   wire wr_resp = wr & (dp_idx == IDX_HOST_RESP);
   wire wr_blen = wr & (dp_idx == IDX_BLOCK_LEN);
   wire wr_csw = wr & (dp_idx == IDX_CUSTOM_SW);
   wire wr_key = wr & (dp_idx == IDX_SEQ_KEY);
   wire wr_capw = wr & (dp_idx == IDX_SEQ_CAP);
   wire wr_arm = wr & (dp_idx == IDX_SEQ_ARM);

   ntp_buffer u_buf (
      .clk(clk),
      .wr_en(wr_buf),
      .wr_idx(dp_idx[11:0]),
      .wr_data(hwdata[7:0]),
      .rda_idx(ap_idx[11:0]),
      .rda_data(bus_buf_data),
      .rdb_idx(data_idx),
      .rdb_data(tx_buf_data)
   );

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dp_wr <= 1'b0;
         dp_idx <= 16'h0000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
      end else begin
         dp_wr <= addr_ok & hwrite;
         dp_idx <= ap_idx;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (addr_ok & ~hwrite) begin
            hrdata <= next_hrdata;
         end
      end
   end

   // read mux; unmapped words read as zero
   always_comb begin
      next_hrdata = 32'h00000000;
      if (ap_idx <= BUF_LAST) begin
         next_hrdata[7:0] = bus_buf_data;
      end else if (ap_idx == IDX_GEN_CTRL) begin
         next_hrdata[15:0] = gen_ctrl;
      end else if (ap_idx == IDX_STATUS) begin
         next_hrdata[3:0] = {cmd_field, state != ST_IDLE, 1'b1};
      end else if (ap_idx == IDX_INT_EN) begin
         next_hrdata[15:0] = int_en;
      end else if (ap_idx == IDX_INT_FLAG) begin
         next_hrdata[15:0] = int_flag;
      end else if (ap_idx == IDX_FILE_ID) begin
         next_hrdata[15:0] = file_id;
      end else if (ap_idx == IDX_HOST_RESP) begin
         next_hrdata[15:0] = host_resp;
      end else if (ap_idx == IDX_BLOCK_LEN) begin
         next_hrdata[15:0] = block_len;
      end else if (ap_idx == IDX_FILE_OFS) begin
         next_hrdata[15:0] = file_ofs;
      end else if (ap_idx == IDX_BUF_START) begin
         next_hrdata[15:0] = buf_start;
      end else if (ap_idx == IDX_CUSTOM_SW) begin
         next_hrdata[15:0] = custom_sw;
      end else if (ap_idx == IDX_RATE_CAP) begin
         next_hrdata[7:0] = rate_cap;
      end else if (ap_idx == IDX_MAP_VER) begin
         next_hrdata[7:0] = MAP_VER_MAX;
      end else if (ap_idx == IDX_MLE_REG) begin
         next_hrdata[15:0] = MLE;
      end else if (ap_idx == IDX_MLC_REG) begin
         next_hrdata[15:0] = MLC;
      end
   end

   // rate sequence: any stray step drops back to the start
   wire seq_open = wr_key & (wdat == SEQ_KEY_OPEN);
   wire seq_s1 = (seq_step == 3'd1) & wr_ctrl & (wdat == SEQ_CTRL_VAL);
   wire seq_s2 = (seq_step == 3'd2) & wr_capw;
   wire seq_s3 = (seq_step == 3'd3) & wr_arm & (wdat == SEQ_ZERO);
   wire seq_s4 = (seq_step == 3'd4) & wr_key & (wdat == SEQ_ZERO);
   wire seq_any = wr_ctrl | wr_capw | wr_arm | wr_key;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         seq_step <= 3'd0;
         cap_pend <= CAP_RESET;
         rate_cap <= CAP_RESET;
      end else begin
         if (seq_s4) begin
            seq_step <= 3'd0;
            if (!cap_pend[CAP_RSVD_BIT]) begin
               rate_cap <= cap_pend;
            end
         end else if (seq_s3) begin
            seq_step <= 3'd4;
         end else if (seq_s2) begin
            seq_step <= 3'd3;
            cap_pend <= hwdata[7:0];
         end else if (seq_s1) begin
            seq_step <= 3'd2;
         end else if (seq_open) begin
            seq_step <= 3'd1;
         end else if (seq_any) begin
            seq_step <= 3'd0;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gen_ctrl <= CTRL_RESET;
         int_en <= INT_EN_RESET;
         custom_sw <= SW_OK;
      end else begin
         if (seq_s4) begin
            gen_ctrl <= CTRL_RESET;
         end else if (wr_ctrl) begin
            gen_ctrl <= wdat;
         end
         if (wr_en_reg) begin
            int_en <= wdat;
         end
         if (wr_csw) begin
            custom_sw <= wdat;
         end
      end
   end

   // frame assembly; extra bytes beyond four are dropped
   wire rf_on = gen_ctrl[CTRL_RF_EN];
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         nbytes <= 3'd0;
         op <= 8'h00;
         arg1 <= 8'h00;
         arg2 <= 8'h00;
         arg3 <= 8'h00;
      end else if (rx.eof) begin
         nbytes <= 3'd0;
      end else if (rx.strobe & rf_on & (nbytes != 3'd4)) begin
         nbytes <= nbytes + 3'd1;
         case (nbytes)
            3'd0: op <= rx.data;
            3'd1: arg1 <= rx.data;
            3'd2: arg2 <= rx.data;
            default: arg3 <= rx.data;
         endcase
      end
   end

   // frame classification at its end
   wire frame = rx.eof & rf_on & (nbytes != 3'd0) & (state == ST_IDLE);
   wire is_wake = (op == OP_WUPB);
   wire is_probe = (op == OP_REQB) | is_wake;
   wire t4_ok = active & ~halted;
   wire do_probe = frame & is_probe & (~halted | is_wake);
   wire do_attrib = frame & (op == OP_ATTRIB) & ~halted;
   wire do_halt = frame & (op == OP_HLTB) & ~halted;
   wire do_sel = frame & (op == OP_SELECT) & t4_ok;
   wire do_upd = frame & (op == OP_UPDATE) & t4_ok;
   wire do_read = frame & (op == OP_READ) & t4_ok;
   wire [15:0] req_ofs = {arg1, arg2};
   wire [7:0] req_len = (arg3 > MLE[7:0]) ? MLE[7:0] : arg3;
   wire [15:0] req_end = req_ofs + {8'h00, req_len};
   wire [15:0] cache_end = cache_ofs + cache_len;
   wire hit = cache_ok & (req_ofs >= cache_ofs) & (req_end <= cache_end);
   wire read_hit = do_read & hit;
   wire read_miss = do_read & ~hit;
   wire raise = do_sel | do_upd | read_miss;
   wire serviced = (state == ST_HOST) & host_resp[HR_SERVICED];
   wire use_custom = host_resp[HR_CUSTOM];
   wire found = host_resp[HR_EXISTS];
   wire [15:0] hit_idx = req_ofs - cache_ofs;

   // anticollision kept local, host never sees it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         halted <= 1'b0;
         active <= 1'b0;
      end else begin
         if (do_probe) begin
            halted <= 1'b0;
            active <= 1'b0;
         end else if (do_attrib) begin
            active <= 1'b1;
         end else if (do_halt) begin
            halted <= 1'b1;
            active <= 1'b0;
         end
      end
   end

   // request description registers for the host
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_field <= T4_NONE;
         file_id <= 16'h0000;
         file_ofs <= 16'h0000;
         buf_start <= 16'h0000;
         rd_ofs <= 16'h0000;
         rd_len <= 8'h00;
      end else if (do_sel) begin
         cmd_field <= T4_SELECT;
         file_id <= {arg1, arg2};
      end else if (do_upd) begin
         cmd_field <= T4_UPDATE;
      end else if (read_miss) begin
         cmd_field <= T4_READ;
         file_id <= sel_fid;
         file_ofs <= req_ofs;
         buf_start <= 16'h0000;
         rd_ofs <= req_ofs;
         rd_len <= req_len;
      end
   end

   // host may overwrite the length with what it really wrote
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         block_len <= 16'h0000;
      end else if (read_miss) begin
         block_len <= {8'h00, req_len};
      end else if (wr_blen) begin
         block_len <= wdat;
      end
   end

   // sticky flag: a new request wins over a same-cycle clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         int_flag <= 16'h0000;
      end else begin
         int_flag[15:1] <= int_flag[15:1] & ~({15{wr_flag}} & wdat[15:1]);
         int_flag[INT_GEN_T4] <= raise
            | (int_flag[INT_GEN_T4] & ~(wr_flag & wdat[INT_GEN_T4]));
      end
   end

   // pin stays high while any enabled flag is set
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         host_interrupt_pin <= 1'b0;
      end else begin
         host_interrupt_pin <= |(int_flag & int_en);
      end
   end

   // serviced bit is consumed by the device when it replies
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         host_resp <= 16'h0000;
      end else if (serviced) begin
         host_resp <= 16'h0000;
      end else if (wr_resp) begin
         host_resp <= wdat;
      end
   end

   // last successful select names the file for reads
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_ok <= 1'b0;
         sel_fid <= 16'h0000;
         cache_ok <= 1'b0;
         cache_ofs <= 16'h0000;
         cache_len <= 16'h0000;
      end else if (do_sel) begin
         cache_ok <= 1'b0;
      end else if (serviced & (cmd_field == T4_SELECT)) begin
         if (~use_custom & found) begin
            sel_ok <= 1'b1;
            sel_fid <= file_id;
         end
      end else if (serviced & (cmd_field == T4_READ)) begin
         cache_ok <= ~use_custom & sel_ok;
         cache_ofs <= rd_ofs;
         cache_len <= block_len;
      end
   end

   // reply sequencing; a select, update or read-miss answer waits in ST_HOST
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         sw <= SW_OK;
         data_idx <= 12'h000;
         remain <= 8'h00;
         tx <= '0;
      end else begin
         tx <= '0;
         case (state)
            ST_IDLE: begin
               if (do_probe) begin
                  sw <= {ATQB_HDR, rate_cap};
                  state <= ST_SW1;
               end else if (do_attrib | do_halt) begin
                  sw <= {ATTRIB_ANS, ATTRIB_ANS};
                  state <= ST_SW1;
               end else if (read_hit) begin
                  sw <= SW_OK;
                  data_idx <= hit_idx[11:0];
                  remain <= req_len;
                  state <= ST_DATA;
               end else if (raise) begin
                  state <= ST_HOST;
               end
            end
            ST_HOST: begin
               if (serviced) begin
                  data_idx <= 12'h000;
                  remain <= 8'h00;
                  state <= ST_SW1;
                  if (use_custom) begin
                     sw <= custom_sw;
                  end else if (cmd_field == T4_SELECT) begin
                     sw <= found ? SW_OK : SW_NOT_FOUND;
                  end else if (cmd_field == T4_READ) begin
                     sw <= SW_OK;
                     remain <= rd_len;
                     state <= ST_DATA;
                  end else begin
                     sw <= SW_OK;
                  end
               end
            end
            ST_DATA: begin
               if (remain == 8'h00) begin
                  state <= ST_SW1;
               end else begin
                  tx.valid <= 1'b1;
                  tx.data <= tx_buf_data;
                  data_idx <= data_idx + 12'h001;
                  remain <= remain - 8'h01;
                  // no idle cycle between data and status bytes
                  if (remain == 8'h01) state <= ST_SW1;
               end
            end
            ST_SW1: begin
               tx.valid <= 1'b1;
               tx.data <= sw[15:8];
               state <= ST_SW2;
            end
            ST_SW2: begin
               tx.valid <= 1'b1;
               tx.last <= 1'b1;
               tx.data <= sw[7:0];
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // size is accepted but not checked: only word transfers are used
   wire unused_ok = &{1'b0, hsize, hwdata[31:16], haddr[31:18],
      haddr[1:0], htrans[0]};
endmodule : ntp_request_proxy

// [verif/ntp_request_proxy_monitor.sv]
`timescale 1ns/1ps
module ntp_proxy_monitor
   import ntp_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic reset_n,
   // ahb-lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // reply and service request
   input wire ntp_tx_t tx,
   input wire logic host_interrupt_pin
);
   logic up;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // hreadyout is a flop, so the first edge still sees it low
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         up <= 1'b0;
      else
         up <= 1'b1;
   end
   sequence wr_at(logic [15:0] i);
      hsel && hready && htrans[1] && hwrite && haddr[17:2] == i;
   endsequence
   sequence rd_at(logic [15:0] i);
      hsel && hready && htrans[1] && !hwrite && haddr[17:2] == i;
   endsequence
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response");
   a_zero_wait: assert property (up |-> hreadyout)
      else $error("wait state");
   a_last_valid: assert property (tx.last |-> tx.valid)
      else $error("last without valid");
   a_reply_run: assert property (tx.valid && !tx.last |=> tx.valid)
      else $error("gap in reply");
   a_serviced_reply: assert property (wr_at(IDX_HOST_RESP) ##1
      hwdata[HR_SERVICED] |-> ##[1:6] tx.valid)
      else $error("no reply after service");
   a_flag_clear: assert property (wr_at(IDX_INT_FLAG) ##1
      hwdata[INT_GEN_T4] |-> ##[1:2] !host_interrupt_pin)
      else $error("pin stays after clear");
   a_mle_value: assert property (rd_at(IDX_MLE_REG) |=>
      hrdata == {16'h0000, MLE}) else $error("bad response limit");
   a_map_version: assert property (rd_at(IDX_MAP_VER) |=>
      hrdata[7:0] <= MAP_VER_MAX) else $error("bad mapping version");
   a_cap_bit3: assert property (rd_at(IDX_RATE_CAP) |=>
      !hrdata[CAP_RSVD_BIT] && hrdata[31:8] == 24'h0)
      else $error("bad capability byte");
endmodule : ntp_proxy_monitor

bind ntp_request_proxy ntp_proxy_monitor mon (.clk(clk), .reset_n(reset_n),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .tx(tx), .host_interrupt_pin(host_interrupt_pin));

// [verif/ntp_reader_model.sv]
`timescale 1ns/1ps
module ntp_reader_model (
   // reader link pins
   output logic link_clk,
   output logic link_frame,
   output logic [7:0] link_data
);
   initial begin
      link_clk = 1'b0;
      link_frame = 1'b0;
      link_data = 8'h00;
   end
   // clock stands still between frames; idle data is inverted, not held
   task automatic send(input logic [31:0] b, input int n);
      link_frame = 1'b1;
      for (int i = 0; i < n; i++) begin
         link_data = b[31-8*i -: 8];
         #100 link_clk = 1'b1;
         #100 link_clk = 1'b0;
      end
      #100 link_frame = 1'b0;
      link_data = ~link_data;
   endtask : send
endmodule : ntp_reader_model

// [verif/ntp_request_proxy_tb.sv]
`timescale 1ns/1ps
module ntp_request_proxy_tb;
   import ntp_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rsp;
   logic hreadyout, hresp, pin, link_clk, link_frame;
   logic [7:0] link_data;
   ntp_tx_t tx;
   int failures, check_count, nb, cyc;
   localparam logic [47:0] ROWS [10] = '{
      {IDX_GEN_CTRL, 32'h0}, {IDX_STATUS, 32'h1}, {IDX_INT_EN, 32'h1},
      {IDX_INT_FLAG, 32'h0}, {IDX_CUSTOM_SW, 32'h9000},
      {IDX_RATE_CAP, 32'h0}, {IDX_MAP_VER, 32'h20}, {IDX_MLE_REG, 32'hF9},
      {IDX_MLC_REG, 32'hF6}, {16'h0BB8, 32'h0}};
   always #12.5 clk = ~clk;
   ntp_request_proxy uut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
      .link_frame(link_frame), .link_data(link_data), .tx(tx),
      .host_interrupt_pin(pin));
   ntp_reader_model rdr (.link_clk(link_clk), .link_frame(link_frame),
      .link_data(link_data));
   always @(posedge clk) begin
      if (tx.valid) begin
         rsp <= {rsp[23:0], tx.data};
         nb <= nb + 1;
      end
   end
   task automatic end_sim;
      if (failures == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         failures++;
         end_sim;
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic ahb(input logic w, input logic [15:0] i, logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {14'h0, i, 2'b00};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic wr(input logic [15:0] i, input logic [31:0] d);
      ahb(1'b1, i, d);
   endtask : wr
   task automatic rdchk(input logic [15:0] i, input logic [31:0] e);
      ahb(1'b0, i, 32'h0);
      check(rd, e);
   endtask : rdchk
   task automatic go(input logic [31:0] f, input int n);
      nb = 0;
      rsp = 32'h0;
      rdr.send(f, n);
   endtask : go
   task automatic expect_rsp(input logic [31:0] e, input int n);
      for (int k = 0; k < 600 && nb < n; k++) @(posedge clk);
      repeat (4) @(posedge clk);
      check(rsp, e);
      check(nb, n);
   endtask : expect_rsp
   // host side of one request, up to the flag clear
   task automatic req(input logic [31:0] f, int n, logic [1:0] c);
      go(f, n);
      repeat (30) @(posedge clk);
      check(pin, 1'b1);
      ahb(1'b0, IDX_STATUS, 32'h0);
      check(rd[3:2], c);
      wr(IDX_INT_FLAG, 32'h1);
      repeat (3) @(posedge clk);
      check(pin, 1'b0);
   endtask : req
   task automatic rate(input logic [7:0] c);
      wr(IDX_SEQ_KEY, 32'h4E);
      wr(IDX_GEN_CTRL, 32'h80);
      wr(IDX_SEQ_CAP, c);
      wr(IDX_SEQ_ARM, 32'h0);
      wr(IDX_SEQ_KEY, 32'h0);
   endtask : rate
   initial begin
      repeat (5) @(posedge clk);
      check(hreadyout, 1'b0);
      check(tx, 32'h0);
      reset_n <= 1'b1;
      foreach (ROWS[i]) begin
         rdchk(ROWS[i][47:32], ROWS[i][31:0]);
      end
      rate(8'h08);
      rdchk(IDX_RATE_CAP, 32'h0);
      rate(8'hF7);
      rdchk(IDX_RATE_CAP, 32'hF7);
      rdchk(IDX_GEN_CTRL, 32'h0);
      wr(BUF_LAST, 32'h5A);
      rdchk(BUF_LAST, 32'h5A);
      wr(IDX_GEN_CTRL, 32'h1);
      go(32'h05000000, 1);
      expect_rsp(32'h50F7, 2);
      go(32'h1D000000, 1);
      expect_rsp(32'h0, 2);
      req(32'hA4E10300, 3, 2'd1);
      rdchk(IDX_FILE_ID, 32'hE103);
      wr(IDX_HOST_RESP, 32'h1);
      expect_rsp(32'h6A82, 2);
      req(32'hA4E10300, 3, 2'd1);
      wr(IDX_CUSTOM_SW, 32'h6A86);
      wr(IDX_HOST_RESP, 32'h3);
      expect_rsp(32'h6A86, 2);
      req(32'hA4E10400, 3, 2'd1);
      rdchk(IDX_FILE_ID, 32'hE104);
      wr(IDX_HOST_RESP, 32'h5);
      expect_rsp(32'h9000, 2);
      req(32'hD6000000, 1, 2'd3);
      wr(IDX_HOST_RESP, 32'h1);
      expect_rsp(32'h9000, 2);
      req(32'hB0000002, 4, 2'd2);
      rdchk(IDX_FILE_OFS, 32'h0);
      rdchk(IDX_BLOCK_LEN, 32'h2);
      rdchk(IDX_BUF_START, 32'h0);
      // cache two bytes past the request
      for (logic [15:0] i = 0; i < 4; i++) wr(i, 32'hC0 + i);
      wr(IDX_BLOCK_LEN, 32'h4);
      wr(IDX_HOST_RESP, 32'h1);
      expect_rsp(32'hC0C19000, 4);
      go(32'hB0000202, 4);
      expect_rsp(32'hC2C39000, 4);
      check(pin, 1'b0);
      req(32'hB0000302, 4, 2'd2);
      rdchk(IDX_FILE_ID, 32'hE104);
      rdchk(IDX_FILE_OFS, 32'h3);
      wr(IDX_CUSTOM_SW, 32'h6B00);
      wr(IDX_HOST_RESP, 32'h3);
      expect_rsp(32'h6B00, 2);
      reset_n <= 1'b0;
      repeat (5) @(posedge clk);
      check(pin, 1'b0);
      reset_n <= 1'b1;
      rdchk(IDX_RATE_CAP, 32'h0);
      end_sim;
   end
endmodule : ntp_request_proxy_tb
